/* verilog/bus_switch_pkg.sv */
// Package with constants for the two-channel I2C bus switch
package bus_switch_pkg;
   localparam logic [6:0] ADDR_BASE = 7'h70;
   localparam int ADDR_SEL_W = 2;
   localparam int CH_N = 2;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int CH0_BIT = 0;
   localparam int CH1_BIT = 1;
   localparam int POR_CYCLES = 4;
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WRITE, ST_WR_ACK, ST_READ, ST_RD_ACK
   } tgt_state_e;
endpackage

/* verilog/pin_sync.sv */
// Two-flop synchroniser for a group of pins
module pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '1
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_ff;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_ff <= INIT;
         q <= INIT;
      end else begin
         meta_ff <= d;
         q <= meta_ff;
      end
   end
endmodule

/* verilog/i2c_two_channel_bus_switch.sv */
// Target state machine, channel switch and interrupt combiner
module i2c_two_channel_bus_switch (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic SCL_I,
   output logic SCL_O,
   output logic SCL_OE,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE,
   input wire logic DOWNSTREAM_CLOCK_CH0_I,
   output logic DOWNSTREAM_CLOCK_CH0_O,
   output logic DOWNSTREAM_CLOCK_CH0_OE,
   input wire logic DOWNSTREAM_DATA_CH0_I,
   output logic DOWNSTREAM_DATA_CH0_O,
   output logic DOWNSTREAM_DATA_CH0_OE,
   input wire logic DOWNSTREAM_CLOCK_CH1_I,
   output logic DOWNSTREAM_CLOCK_CH1_O,
   output logic DOWNSTREAM_CLOCK_CH1_OE,
   input wire logic DOWNSTREAM_DATA_CH1_I,
   output logic DOWNSTREAM_DATA_CH1_O,
   output logic DOWNSTREAM_DATA_CH1_OE,
   input wire logic IRQ_IN_CH0_N,
   input wire logic IRQ_IN_CH1_N,
   output logic IRQ_OUT_N,
   input wire logic ADDR_SEL_0,
   input wire logic ADDR_SEL_1,
   output logic [1:0] CHANNEL_ENABLE
);
   // Synchronised pins: scl, sda, ds clk/data x2, irq x2, addr x2
   logic [9:0] raw;
   logic [9:0] syn;
   assign raw = {ADDR_SEL_1, ADDR_SEL_0, IRQ_IN_CH1_N, IRQ_IN_CH0_N,
                 DOWNSTREAM_DATA_CH1_I, DOWNSTREAM_CLOCK_CH1_I,
                 DOWNSTREAM_DATA_CH0_I, DOWNSTREAM_CLOCK_CH0_I,
                 SDA_I, SCL_I};

   pin_sync #(.W(10), .INIT(10'h0FF)) u_sync (
      .clk(CLK),
      .rst_b(RST_B),
      .d(raw),
      .q(syn)
   );

   wire scl_s = syn[0];
   wire sda_s = syn[1];
   wire [1:0] ds_clk = {syn[4], syn[2]};
   wire [1:0] ds_dat = {syn[5], syn[3]};
   wire [1:0] irq_n = {syn[7], syn[6]};
   wire [1:0] addr_sel = {syn[9], syn[8]};

   // Power-on reset stretch, cleared by the pin as well
   logic [2:0] por_cnt_ff;
   wire por_busy = (por_cnt_ff != 3'(bus_switch_pkg::POR_CYCLES));
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) por_cnt_ff <= '0;
      else if (por_busy) por_cnt_ff <= por_cnt_ff + 3'h1;
   end

   logic scl_d_ff;
   logic sda_d_ff;
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         scl_d_ff <= scl_s;
         sda_d_ff <= sda_s;
      end
   end
   wire scl_rise = scl_s & ~scl_d_ff;
   wire scl_fall = ~scl_s & scl_d_ff;
   wire start_c = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
   wire stop_c = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

   // Address compare: fixed high bits, pins give low bits
   wire [6:0] my_addr = {bus_switch_pkg::ADDR_BASE[6:2], addr_sel};

   bus_switch_pkg::tgt_state_e st_ff;
   bus_switch_pkg::tgt_state_e nxt_st;
   logic [7:0] sh_ff;
   logic [7:0] nxt_sh;
   logic [3:0] bit_ff;
   logic [3:0] nxt_bit;
   logic [7:0] ctrl_ff;
   logic [7:0] nxt_ctrl;
   logic sda_low_ff;
   logic nxt_sda_low;

   wire byte_done = (bit_ff == 4'h8);
   wire addr_hit = (sh_ff[7:1] == my_addr);

   always_comb begin
      nxt_st = st_ff;
      nxt_sh = sh_ff;
      nxt_bit = bit_ff;
      nxt_ctrl = ctrl_ff;
      nxt_sda_low = sda_low_ff;
      if (start_c) begin
         nxt_st = bus_switch_pkg::ST_ADDR;
         nxt_bit = 4'h0;
         nxt_sda_low = 1'b0;
      end else if (stop_c) begin
         nxt_st = bus_switch_pkg::ST_IDLE;
         nxt_sda_low = 1'b0;
      end else begin
         unique case (st_ff)
            bus_switch_pkg::ST_IDLE: begin
               nxt_sda_low = 1'b0;
            end
            bus_switch_pkg::ST_ADDR, bus_switch_pkg::ST_WRITE: begin
               if (scl_rise && !byte_done) begin
                  nxt_sh = {sh_ff[6:0], sda_s};
                  nxt_bit = bit_ff + 4'h1;
               end else if (scl_fall && byte_done) begin
                  if (st_ff == bus_switch_pkg::ST_WRITE) begin
                     nxt_ctrl = sh_ff;
                     nxt_sda_low = 1'b1;
                     nxt_st = bus_switch_pkg::ST_WR_ACK;
                  end else if (addr_hit) begin
                     nxt_sda_low = 1'b1;
                     nxt_st = bus_switch_pkg::ST_ADDR_ACK;
                  end else begin
                     nxt_st = bus_switch_pkg::ST_IDLE;
                  end
               end
            end
            bus_switch_pkg::ST_ADDR_ACK, bus_switch_pkg::ST_WR_ACK: begin
               if (scl_fall) begin
                  nxt_bit = 4'h0;
                  if (st_ff == bus_switch_pkg::ST_ADDR_ACK && sh_ff[0]) begin
                     nxt_st = bus_switch_pkg::ST_READ;
                     nxt_sh = ctrl_ff;
                     nxt_sda_low = ~ctrl_ff[7];
                  end else begin
                     nxt_st = bus_switch_pkg::ST_WRITE;
                     nxt_sda_low = 1'b0;
                  end
               end
            end
            bus_switch_pkg::ST_READ: begin
               if (scl_fall) begin
                  if (bit_ff == 4'h7) begin
                     nxt_sda_low = 1'b0;
                     nxt_st = bus_switch_pkg::ST_RD_ACK;
                  end else begin
                     nxt_bit = bit_ff + 4'h1;
                     nxt_sh = {sh_ff[6:0], 1'b0};
                     nxt_sda_low = ~sh_ff[6];
                  end
               end
            end
            bus_switch_pkg::ST_RD_ACK: begin
               if (scl_rise && sda_s) begin
                  nxt_st = bus_switch_pkg::ST_IDLE;
               end else if (scl_fall) begin
                  nxt_bit = 4'h0;
                  nxt_sh = ctrl_ff;
                  nxt_sda_low = ~ctrl_ff[7];
                  nxt_st = bus_switch_pkg::ST_READ;
               end
            end
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         st_ff <= bus_switch_pkg::ST_IDLE;
         sh_ff <= 8'h00;
         bit_ff <= 4'h0;
         ctrl_ff <= bus_switch_pkg::CTRL_RESET;
         sda_low_ff <= 1'b0;
      end else if (por_busy) begin
         st_ff <= bus_switch_pkg::ST_IDLE;
         sh_ff <= 8'h00;
         bit_ff <= 4'h0;
         ctrl_ff <= bus_switch_pkg::CTRL_RESET;
         sda_low_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         sh_ff <= nxt_sh;
         bit_ff <= nxt_bit;
         ctrl_ff <= nxt_ctrl;
         sda_low_ff <= nxt_sda_low;
      end
   end

   // Channel enables from control bits
   wire [1:0] ch_en = {ctrl_ff[bus_switch_pkg::CH1_BIT],
                       ctrl_ff[bus_switch_pkg::CH0_BIT]};

   // Open-drain pass: a low seen on one side is driven on the other.
   // A line we released still reads low for two cycles through the
   // synchroniser, so lows inside that echo window are not fed back;
   // otherwise the two sides would hold each other low and oscillate.
   logic [1:0] ds_clk_oe_ff;
   logic [1:0] ds_dat_oe_ff;
   logic [1:0] ds_clk_d1_ff;
   logic [1:0] ds_clk_d2_ff;
   logic [1:0] ds_dat_d1_ff;
   logic [1:0] ds_dat_d2_ff;
   logic scl_oe_ff;
   logic sda_oe_ff;
   // Upstream drive history: bit 1 data, bit 0 clock
   logic [1:0] up_d1_ff;
   logic [1:0] up_d2_ff;
   logic irq_ff;
   logic [1:0] en_ff;
   logic [1:0] ds_clk_low;
   logic [1:0] ds_dat_low;
   logic [1:0] nxt_ds_clk_oe;
   logic [1:0] nxt_ds_dat_oe;
   wire [1:0] ds_clk_own = ds_clk_oe_ff | ds_clk_d1_ff | ds_clk_d2_ff;
   wire [1:0] ds_dat_own = ds_dat_oe_ff | ds_dat_d1_ff | ds_dat_d2_ff;
   wire scl_own = scl_oe_ff | up_d1_ff[0] | up_d2_ff[0];
   wire sda_own = sda_oe_ff | up_d1_ff[1] | up_d2_ff[1];
   genvar g;
   generate
      for (g = 0; g < bus_switch_pkg::CH_N; g++) begin : g_ch
         assign ds_clk_low[g] = ch_en[g] & ~ds_clk[g] & ~ds_clk_own[g];
         assign ds_dat_low[g] = ch_en[g] & ~ds_dat[g] & ~ds_dat_own[g];
         assign nxt_ds_clk_oe[g] = ch_en[g] & ~scl_s & ~scl_own;
         assign nxt_ds_dat_oe[g] = ch_en[g] &
                                   ((~sda_s & ~sda_own) | sda_low_ff);
      end
   endgenerate

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         ds_clk_oe_ff <= 2'h0;
         ds_dat_oe_ff <= 2'h0;
         ds_clk_d1_ff <= 2'h0;
         ds_clk_d2_ff <= 2'h0;
         ds_dat_d1_ff <= 2'h0;
         ds_dat_d2_ff <= 2'h0;
         up_d1_ff <= 2'h0;
         up_d2_ff <= 2'h0;
      end else begin
         ds_clk_oe_ff <= nxt_ds_clk_oe;
         ds_dat_oe_ff <= nxt_ds_dat_oe;
         ds_clk_d1_ff <= ds_clk_oe_ff;
         ds_clk_d2_ff <= ds_clk_d1_ff;
         ds_dat_d1_ff <= ds_dat_oe_ff;
         ds_dat_d2_ff <= ds_dat_d1_ff;
         up_d1_ff <= {sda_oe_ff, scl_oe_ff};
         up_d2_ff <= up_d1_ff;
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         scl_oe_ff <= 1'b0;
         sda_oe_ff <= 1'b0;
         irq_ff <= 1'b1;
         en_ff <= 2'h0;
      end else begin
         scl_oe_ff <= |ds_clk_low;
         sda_oe_ff <= sda_low_ff | (|ds_dat_low);
         irq_ff <= &irq_n;
         en_ff <= ch_en;
      end
   end

   assign SCL_O = 1'b0;
   assign SDA_O = 1'b0;
   assign SCL_OE = scl_oe_ff;
   assign SDA_OE = sda_oe_ff;
   assign DOWNSTREAM_CLOCK_CH0_O = 1'b0;
   assign DOWNSTREAM_DATA_CH0_O = 1'b0;
   assign DOWNSTREAM_CLOCK_CH1_O = 1'b0;
   assign DOWNSTREAM_DATA_CH1_O = 1'b0;
   assign DOWNSTREAM_CLOCK_CH0_OE = ds_clk_oe_ff[0];
   assign DOWNSTREAM_DATA_CH0_OE = ds_dat_oe_ff[0];
   assign DOWNSTREAM_CLOCK_CH1_OE = ds_clk_oe_ff[1];
   assign DOWNSTREAM_DATA_CH1_OE = ds_dat_oe_ff[1];
   assign IRQ_OUT_N = irq_ff;
   assign CHANNEL_ENABLE = en_ff;
endmodule

/* tb/bus_switch_chk.sv */
// Port checker for the two-channel bus switch
module bus_switch_chk (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic SCL_I,
   input wire logic SCL_O,
   input wire logic SCL_OE,
   input wire logic SDA_O,
   input wire logic DOWNSTREAM_CLOCK_CH0_O,
   input wire logic DOWNSTREAM_DATA_CH0_O,
   input wire logic DOWNSTREAM_CLOCK_CH1_O,
   input wire logic DOWNSTREAM_DATA_CH1_O,
   input wire logic DOWNSTREAM_CLOCK_CH0_OE,
   input wire logic DOWNSTREAM_DATA_CH0_OE,
   input wire logic DOWNSTREAM_CLOCK_CH1_OE,
   input wire logic DOWNSTREAM_DATA_CH1_OE,
   input wire logic IRQ_IN_CH0_N,
   input wire logic IRQ_IN_CH1_N,
   input wire logic IRQ_OUT_N,
   input wire logic [1:0] CHANNEL_ENABLE
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);
   sequence irq_quiet;
      $stable({IRQ_IN_CH0_N, IRQ_IN_CH1_N}) [*4];
   endsequence
   sequence up_low(logic en);
      en && !SCL_I && !SCL_OE [*5];
   endsequence
   chk_irq_and:
   assert property (irq_quiet |-> IRQ_OUT_N == (IRQ_IN_CH0_N & IRQ_IN_CH1_N))
      else $error("irq out not and of inputs");
   chk_por_hold:
   assert property ($rose(RST_B) |-> (CHANNEL_ENABLE == 2'h0) [*4])
      else $error("channel enabled after reset");
   chk_off_ch0:
   assert property (!CHANNEL_ENABLE[0] [*3] |->
      !DOWNSTREAM_CLOCK_CH0_OE && !DOWNSTREAM_DATA_CH0_OE)
      else $error("channel 0 driven while off");
   chk_off_ch1:
   assert property (!CHANNEL_ENABLE[1] [*3] |->
      !DOWNSTREAM_CLOCK_CH1_OE && !DOWNSTREAM_DATA_CH1_OE)
      else $error("channel 1 driven while off");
   chk_pass_ch0:
   assert property (up_low(CHANNEL_ENABLE[0]) |-> DOWNSTREAM_CLOCK_CH0_OE)
      else $error("clock low not passed to channel 0");
   chk_pass_ch1:
   assert property (up_low(CHANNEL_ENABLE[1]) |-> DOWNSTREAM_CLOCK_CH1_OE)
      else $error("clock low not passed to channel 1");
   chk_od_low:
   assert property (SCL_O == 1'h0 && SDA_O == 1'h0 &&
      {DOWNSTREAM_CLOCK_CH0_O, DOWNSTREAM_DATA_CH0_O,
       DOWNSTREAM_CLOCK_CH1_O, DOWNSTREAM_DATA_CH1_O} == 4'h0)
      else $error("open-drain output drives high");
   chk_en_stop:
   assert property ($changed(CHANNEL_ENABLE) |-> SCL_I)
      else $error("channel set changed with clock low");
endmodule

/* tb/i2c_host_model.sv */
// Upstream bus master model with bit-level tasks
module i2c_host_model (
   output logic scl_oe,
   output logic sda_oe,
   input wire logic scl,
   input wire logic sda
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      scl_oe = 1'h0;
      sda_oe = 1'h0;
   end
   // Data moves only while the clock is low; sampled mid high phase
   task automatic bit_io(input logic b, output logic r);
      #20 sda_oe = !b;
      #60 scl_oe = 1'h0;
      #40 r = sda;
      #40 scl_oe = 1'h1;
   endtask
   // Host holds the clock low (1) or lets it go (0)
   task automatic hold_scl(input logic v);
      scl_oe = v;
   endtask
   task automatic start();
      sda_oe = 1'h0;
      #40 scl_oe = 1'h0;
      #40 sda_oe = 1'h1;
      #40 scl_oe = 1'h1;
   endtask
   task automatic stop();
      #20 sda_oe = 1'h1;
      #40 scl_oe = 1'h0;
      #40 sda_oe = 1'h0;
      #80;
   endtask
   // Host sends a byte MSB first, then gives or reads the ninth bit
   task automatic xfer(input logic [7:0] d, input logic mack,
                       output logic [7:0] q, output logic sack);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(mack, sack);
   endtask
endmodule

/* tb/testbench.sv */
// Self-checking bench for the two-channel bus switch
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'h0;
   logic rst_b = 1'h0;
   logic irq0_n = 1'h1;
   logic irq1_n = 1'h1;
   logic [1:0] sel = 2'h0;
   logic ds_pull = 1'h0;
   logic m_scl, m_sda, scl_oe, sda_oe, c0_oe, d0_oe, c1_oe, d1_oe, irq_n;
   logic [1:0] ch_en;
   int failures = 0;
   int cmp_count = 0;
   wire scl = !(m_scl | scl_oe);
   wire sda = !(m_sda | sda_oe);
   always #10 clk = ~clk;
   i2c_host_model mdl (.scl_oe(m_scl), .sda_oe(m_sda), .scl(scl), .sda(sda));
   i2c_two_channel_bus_switch uut (.CLK(clk), .RST_B(rst_b),
      .SCL_I(scl), .SCL_O(), .SCL_OE(scl_oe),
      .SDA_I(sda), .SDA_O(), .SDA_OE(sda_oe),
      .DOWNSTREAM_CLOCK_CH0_I(!c0_oe), .DOWNSTREAM_CLOCK_CH0_O(),
      .DOWNSTREAM_CLOCK_CH0_OE(c0_oe),
      .DOWNSTREAM_DATA_CH0_I(!d0_oe), .DOWNSTREAM_DATA_CH0_O(),
      .DOWNSTREAM_DATA_CH0_OE(d0_oe),
      .DOWNSTREAM_CLOCK_CH1_I(!c1_oe), .DOWNSTREAM_CLOCK_CH1_O(),
      .DOWNSTREAM_CLOCK_CH1_OE(c1_oe),
      .DOWNSTREAM_DATA_CH1_I(!(d1_oe | ds_pull)), .DOWNSTREAM_DATA_CH1_O(),
      .DOWNSTREAM_DATA_CH1_OE(d1_oe),
      .IRQ_IN_CH0_N(irq0_n), .IRQ_IN_CH1_N(irq1_n), .IRQ_OUT_N(irq_n),
      .ADDR_SEL_0(sel[0]), .ADDR_SEL_1(sel[1]), .CHANNEL_ENABLE(ch_en));
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wrap_up();
      if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   function automatic logic [6:0] adr(logic [1:0] s);
      return {bus_switch_pkg::ADDR_BASE[6:2], s};
   endfunction
   task automatic op(logic [6:0] a, logic rd, logic [7:0] d,
                     output logic ack, output logic [7:0] q);
      logic x;
      mdl.start();
      mdl.xfer({a, rd}, 1'h1, q, ack);
      if (ack === 1'h0) mdl.xfer(rd ? 8'hff : d, 1'h1, q, x);
      mdl.stop();
      repeat (6) @(negedge clk);
   endtask
   task automatic t_reset();
      chk("channel_enable", 8'h00, ch_en);
      chk("irq_out", 8'h01, irq_n);
      chk("down_oe", 8'h00, {c0_oe, d0_oe, c1_oe, d1_oe});
   endtask
   task automatic t_irq();
      for (int k = 0; k < 4; k++) begin
         {irq1_n, irq0_n} = k[1:0];
         repeat (6) @(negedge clk);
         chk("irq_out", 8'(k == 3), irq_n);
      end
   endtask
   task automatic t_sel();
      logic a;
      logic [7:0] q;
      for (int s = 0; s < 4; s++) begin
         sel = s[1:0];
         repeat (4) @(negedge clk);
         op(adr(s[1:0]), 1'h0, 8'(s), a, q);
         chk("write_ack", 8'h00, a);
         chk("channel_enable", 8'(s), ch_en);
         op(adr(s[1:0]), 1'h1, 8'h00, a, q);
         chk("read_ctrl", 8'(s), q);
         op(adr(~s[1:0]), 1'h0, 8'h00, a, q);
         chk("foreign_ack", 8'h01, a);
         chk("channel_kept", 8'(s), ch_en);
      end
   endtask
   task automatic t_pass();
      int n;
      logic a;
      logic [7:0] q;
      mdl.hold_scl(1'h1);
      repeat (6) @(negedge clk);
      chk("down_clk_oe", 8'h03, {c1_oe, c0_oe});
      ds_pull = 1'h1;
      for (n = 0; n < 10 && sda_oe !== 1'h1; n++) @(negedge clk);
      chk("up_sda_oe", 8'h01, sda_oe);
      ds_pull = 1'h0;
      repeat (6) @(negedge clk);
      chk("up_sda_free", 8'h00, sda_oe);
      mdl.hold_scl(1'h0);
      repeat (6) @(negedge clk);
      chk("scl_free", 8'h00, {scl_oe, c1_oe, c0_oe});
      op(adr(sel), 1'h0, 8'h00, a, q);
      chk("channel_off", 8'h00, ch_en);
   endtask
   task automatic t_midreset();
      logic a;
      logic [7:0] q;
      op(adr(sel), 1'h0, 8'h03, a, q);
      chk("channel_before", 8'h03, ch_en);
      rst_b = 1'h0;
      repeat (2) @(negedge clk);
      chk("channel_in_reset", 8'h00, ch_en);
      rst_b = 1'h1;
      repeat (12) @(negedge clk);
      t_reset();
      op(adr(sel), 1'h0, 8'h02, a, q);
      chk("channel_after", 8'h02, ch_en);
   endtask
   initial begin
      repeat (5) @(negedge clk);
      rst_b = 1'h1;
      repeat (12) @(negedge clk);
      t_reset();
      t_irq();
      t_sel();
      t_pass();
      t_midreset();
      wrap_up();
   end
endmodule
bind i2c_two_channel_bus_switch bus_switch_chk chk (.*);
